// file: rtl/bte_pkg.sv
// Shared constants, types and register map of the bit and transfer executor.
// Assumes one 25 MHz clock and a synchronous active-high reset everywhere.
package bte_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus register byte offsets
  localparam logic [4:0] ADDR_INSTR  = 5'h00;
  localparam logic [4:0] ADDR_FLAGS  = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_REGVW  = 5'h0c;
  localparam logic [4:0] ADDR_SP     = 5'h10;

  // Status register fields
  localparam int STAT_BUSY   = 0;
  localparam int STAT_BADOP  = 1;
  localparam int STAT_CNT_LO = 8;
  localparam int STAT_CNT_HI = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Flag register bit positions
  localparam logic [2:0] FLG_CARRY    = 3'h0;
  localparam logic [2:0] FLG_ZERO     = 3'h1;
  localparam logic [2:0] FLG_NEGATIVE = 3'h2;
  localparam logic [2:0] FLG_OVERFLOW = 3'h3;
  localparam logic [2:0] FLG_SIGNED   = 3'h4;
  localparam logic [2:0] FLG_HALF     = 3'h5;
  localparam logic [2:0] FLG_TRANSFER = 3'h6;
  localparam logic [2:0] FLG_IRQ_EN   = 3'h7;

  // Reset values and sizes
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SP_RESET    = 8'h7f;
  localparam int         NUM_GPR     = 16;
  localparam int         DMEM_DEPTH  = 128;
  localparam int         DMEM_AW     = 7;
  localparam int         IO_DEPTH    = 64;
  localparam int         IO_AW       = 6;

  // Pointer pairs: low byte index of X, Y and Z
  localparam logic [3:0] PTR_BASE    = 4'ha;
  localparam logic [1:0] PTR_SEL_Z   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes (own encoding, bits 31:26 of the issue word)
  typedef enum logic [5:0] {
    OP_IDLE       = 6'h00, OP_IO_SET   = 6'h01, OP_IO_CLR   = 6'h02,
    OP_FLAG_CAP   = 6'h03, OP_FLAG_RST = 6'h04, OP_FLAG_SET = 6'h05,
    OP_FLAG_CLR   = 6'h06, OP_COPY     = 6'h07, OP_LDI      = 6'h08,
    OP_LD         = 6'h09, OP_LD_INC   = 6'h0a, OP_LD_DEC   = 6'h0b,
    OP_LDS        = 6'h0c, OP_ST       = 6'h0d, OP_ST_INC   = 6'h0e,
    OP_ST_DEC     = 6'h0f, OP_STS      = 6'h10, OP_IN       = 6'h11,
    OP_OUT        = 6'h12, OP_PUSH     = 6'h13, OP_POP      = 6'h14,
    OP_BREAK      = 6'h15, OP_SLEEP    = 6'h16, OP_WDR      = 6'h17
  } bte_op_t;

  // Issue word layout
  typedef struct packed {
    bte_op_t    op;      // 31:26
    logic [1:0] rsv_hi;  // 25:24
    logic [3:0] rd;      // 23:20 destination register
    logic [3:0] rr;      // 19:16 source register
    logic [7:0] k;       // 15:8 constant, address or pointer select
    logic [4:0] rsv_lo;  // 7:3
    logic [2:0] bt;      // 2:0 bit or flag index
  } bte_instr_t;

  // Execution sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EX1  = 2'b01,
    ST_EX2  = 2'b10
  } bte_state_t;

endpackage

// file: rtl/bte_mem.sv
// Single-port byte memory with per-bit write mask and registered read data.
// Assumes the caller never needs the written value back in the same cycle.
`timescale 1ns/100ps
module bte_mem #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [7:0]    wmask,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    q
);

  logic [7:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Masked write lets a single bit change without a read cycle first
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
    end
  end

  // Read returns the old contents on a write to the same address
  always_ff @(posedge clk) begin
    q <= mem[addr];
  end

endmodule

// file: rtl/bte_exec.sv
// Execution unit for bit, flag, data transfer and core control instructions.
// Assumes software issues words over Avalon-MM; data memory and I/O space are local.
//
// Contract
// - Set I/O bit: selected I/O bit goes to one, flags kept, one cycle.
// - Clear I/O bit: selected I/O bit goes to zero, flags kept, one cycle.
// - Bit capture: register bit copied into transfer flag only, one cycle.
// - Bit restore: transfer flag written into register bit, flags kept, one cycle.
// - Carry, negative, zero, signed, interrupt flags set or cleared singly, one cycle.
// - Overflow, transfer, half-carry flags set or cleared singly, one cycle.
// - Post-increment load: read at pointer into register, then pointer plus one; two cycles.
// - Pre-decrement load: pointer minus one, read new address into register; two cycles.
// - Post-increment store: write register at pointer, pointer plus one; one cycle.
// - Pre-decrement store: pointer minus one, then write at new address; two cycles.
// - Direct load: byte at constant address into register, one cycle, flags kept.
// - Direct store: register to constant address, one cycle, flags kept.
// - Port in and out: whole byte between register and I/O location, one cycle.
// - Push: register onto stack, flags kept, two cycles.
// - Pop: stack top into register, flags kept, two cycles.
// - Break, sleep, watchdog restart: one cycle, flags kept, pulse outward; idle: one cycle, flags kept, no pulse.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module bte_exec import bte_pkg::*; (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic      [7:0]  FLAG_REG,
  output logic             BREAK_PULSE,
  output logic             SLEEP_PULSE,
  output logic             WDOG_RESTART
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  gpr_r [NUM_GPR];
  bte_instr_t  instr_r;
  bte_instr_t  new_instr;
  bte_state_t  state_r;
  bte_state_t  state_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  sp_r;
  logic [3:0]  exec_cnt_r;
  logic        bad_op_r;
  logic [3:0]  reg_sel_r;
  logic        rd_valid_r;
  logic [31:0] readdata_r;
  logic        brk_r;
  logic        slp_r;
  logic        wdr_r;
  logic        wr_ok;
  logic        accept;
  logic        ex1;
  logic        ex2;
  logic [3:0]  ptr_lo;
  logic [3:0]  ptr_hi;
  logic [3:0]  acc_lo;
  logic [3:0]  acc_hi;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_acc;
  logic [15:0] ptr_nxt;
  logic        ptr_wr;
  logic        rd_wr;
  logic [7:0]  rd_val;
  logic [7:0]  dmem_addr;
  logic        dmem_we;
  logic [7:0]  dmem_q;
  logic [5:0]  io_addr;
  logic        io_we;
  logic [7:0]  io_mask;
  logic [7:0]  io_wdata;
  logic [7:0]  io_q;
  logic [7:0]  bit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  function automatic logic two_cycle(input bte_op_t op);
    return op inside {OP_LD_INC, OP_LD_DEC, OP_ST_DEC, OP_PUSH, OP_POP};
  endfunction

  function automatic logic legal_op(input bte_op_t op);
    return op inside {OP_IDLE, OP_IO_SET, OP_IO_CLR, OP_FLAG_CAP, OP_FLAG_RST,
                      OP_FLAG_SET, OP_FLAG_CLR, OP_COPY, OP_LDI, OP_LD,
                      OP_LD_INC, OP_LD_DEC, OP_LDS, OP_ST, OP_ST_INC,
                      OP_ST_DEC, OP_STS, OP_IN, OP_OUT, OP_PUSH, OP_POP,
                      OP_BREAK, OP_SLEEP, OP_WDR};
  endfunction

  // Select code three aliases Z so no index runs past the file
  function automatic logic [3:0] ptr_index(input logic [1:0] sel);
    logic [1:0] s;
    s = (sel > PTR_SEL_Z) ? PTR_SEL_Z : sel;
    return PTR_BASE + {1'b0, s, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; every write waits while an instruction is in flight
  assign new_instr = bte_instr_t'(AVS_WRITEDATA);
  assign wr_ok     = AVS_WRITE && (state_r == ST_IDLE);
  assign accept    = wr_ok && (AVS_ADDRESS == ADDR_INSTR);
  assign ex1       = (state_r == ST_EX1);
  assign ex2       = (state_r == ST_EX2);

  // Reads answer one cycle later from a register; writes stall on busy
  assign AVS_WAITREQUEST = (AVS_READ && !rd_valid_r) || (AVS_WRITE && (state_r != ST_IDLE));
  assign AVS_READDATA    = readdata_r;
  assign FLAG_REG        = flags_r;
  assign BREAK_PULSE     = brk_r;
  assign SLEEP_PULSE     = slp_r;
  assign WDOG_RESTART    = wdr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one or two execution cycles after the issue edge
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_EX1;
        end
      end
      ST_EX1: begin
        state_nxt = two_cycle(instr_r.op) ? ST_EX2 : ST_IDLE;
      end
      ST_EX2: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latched instruction and cycle count of the last one
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      instr_r    <= '0;
      exec_cnt_r <= 4'h0;
    end else if (accept) begin
      instr_r    <= new_instr;
      exec_cnt_r <= 4'h0;
    end else if (state_r != ST_IDLE) begin
      exec_cnt_r <= exec_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer pairs, for the issue word and for the latched instruction
  assign acc_lo  = ptr_index(new_instr.k[1:0]);
  assign acc_hi  = acc_lo + 4'h1;
  assign ptr_lo  = ptr_index(instr_r.k[1:0]);
  assign ptr_hi  = ptr_lo + 4'h1;
  assign ptr_acc = {gpr_r[acc_hi], gpr_r[acc_lo]};
  assign ptr_cur = {gpr_r[ptr_hi], gpr_r[ptr_lo]};

  // Pre-decrement forms step down, post-increment forms step up
  assign ptr_nxt = (instr_r.op inside {OP_LD_DEC, OP_ST_DEC}) ? ptr_cur - 16'h0001
                                                              : ptr_cur + 16'h0001;
  assign ptr_wr  = (ex1 && (instr_r.op == OP_ST_INC)) ||
                   (ex2 && (instr_r.op inside {OP_LD_INC, OP_LD_DEC, OP_ST_DEC}));

  ////////////////////////////////////////////////////////////////////////////
  // Data memory address: reads launch on the issue edge so the
  // byte is ready in the first execution cycle; writes use the latched word
  always_comb begin
    dmem_addr = ptr_cur[7:0];
    if (state_r == ST_IDLE) begin
      unique case (new_instr.op)
        OP_LD_DEC: dmem_addr = ptr_acc[7:0] - 8'h01;
        OP_LDS:    dmem_addr = new_instr.k;
        OP_POP:    dmem_addr = sp_r + 8'h01;
        default:   dmem_addr = ptr_acc[7:0];
      endcase
    end else begin
      unique case (instr_r.op)
        OP_ST_DEC: dmem_addr = ptr_cur[7:0] - 8'h01;
        OP_STS:    dmem_addr = instr_r.k;
        OP_PUSH:   dmem_addr = sp_r;
        default:   dmem_addr = ptr_cur[7:0];
      endcase
    end
  end

  assign dmem_we = ex1 && (instr_r.op inside {OP_ST, OP_ST_INC, OP_ST_DEC, OP_STS, OP_PUSH});

  bte_mem #(
    .DEPTH (DMEM_DEPTH),
    .AW    (DMEM_AW)
  ) u_dmem (
    .clk   (SYS_CLK),
    .addr  (dmem_addr[DMEM_AW-1:0]),
    .we    (dmem_we),
    .wmask (8'hff),
    .wdata (gpr_r[instr_r.rr]),
    .q     (dmem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // I/O space; bit writes use the mask so no read-modify-write cycle is spent
  assign bit_mask = 8'h01 << instr_r.bt;
  assign io_addr  = (state_r == ST_IDLE) ? new_instr.k[IO_AW-1:0] : instr_r.k[IO_AW-1:0];
  assign io_we    = ex1 && (instr_r.op inside {OP_IO_SET, OP_IO_CLR, OP_OUT});
  assign io_mask  = (instr_r.op == OP_OUT) ? 8'hff : bit_mask;
  assign io_wdata = (instr_r.op == OP_OUT)    ? gpr_r[instr_r.rr] :
                    (instr_r.op == OP_IO_SET) ? 8'hff : 8'h00;

  bte_mem #(
    .DEPTH (IO_DEPTH),
    .AW    (IO_AW)
  ) u_iomem (
    .clk   (SYS_CLK),
    .addr  (io_addr),
    .we    (io_we),
    .wmask (io_mask),
    .wdata (io_wdata),
    .q     (io_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Destination register value, written at the end of the first cycle
  always_comb begin
    rd_val = gpr_r[instr_r.rd];
    rd_wr  = ex1;
    unique case (instr_r.op)
      OP_FLAG_RST: rd_val = (gpr_r[instr_r.rd] & ~bit_mask) |
                            (flags_r[FLG_TRANSFER] ? bit_mask : 8'h00);
      OP_COPY:     rd_val = gpr_r[instr_r.rr];
      OP_LDI:      rd_val = instr_r.k;
      OP_LD,
      OP_LD_INC,
      OP_LD_DEC,
      OP_LDS,
      OP_POP:      rd_val = dmem_q;
      OP_IN:       rd_val = io_q;
      default:     rd_wr  = 1'b0;
    endcase
  end

  // Working registers; a pointer update lands after the data write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_r[i] <= 8'h00;
      end
    end else begin
      if (rd_wr) begin
        gpr_r[instr_r.rd] <= rd_val;
      end
      if (ptr_wr) begin
        gpr_r[ptr_lo] <= ptr_nxt[7:0];
        gpr_r[ptr_hi] <= ptr_nxt[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register; transfer ops never touch any other flag
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      flags_r <= FLAGS_RESET;
    end else if (wr_ok && (AVS_ADDRESS == ADDR_FLAGS)) begin
      flags_r <= AVS_WRITEDATA[7:0];
    end else if (ex1) begin
      unique case (instr_r.op)
        OP_FLAG_CAP: flags_r[FLG_TRANSFER] <= gpr_r[instr_r.rr][instr_r.bt];
        OP_FLAG_SET: flags_r[instr_r.bt]   <= 1'b1;
        OP_FLAG_CLR: flags_r[instr_r.bt]   <= 1'b0;
        default:     flags_r               <= flags_r;
      endcase
    end
  end

  // Stack pointer: push stores then steps down, pop steps up in cycle two
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sp_r <= SP_RESET;
    end else if (wr_ok && (AVS_ADDRESS == ADDR_SP)) begin
      sp_r <= AVS_WRITEDATA[7:0];
    end else if (ex2 && (instr_r.op == OP_PUSH)) begin
      sp_r <= sp_r - 8'h01;
    end else if (ex2 && (instr_r.op == OP_POP)) begin
      sp_r <= sp_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pulses; what they cause is up to the units listening
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      brk_r <= 1'b0;
      slp_r <= 1'b0;
      wdr_r <= 1'b0;
    end else begin
      brk_r <= ex1 && (instr_r.op == OP_BREAK);
      slp_r <= ex1 && (instr_r.op == OP_SLEEP);
      wdr_r <= ex1 && (instr_r.op == OP_WDR);
    end
  end

  // Unknown code runs as idle; sticky mark, set beats a clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bad_op_r <= 1'b0;
    end else if (accept && !legal_op(new_instr.op)) begin
      bad_op_r <= 1'b1;
    end else if (wr_ok && (AVS_ADDRESS == ADDR_STATUS) && AVS_WRITEDATA[STAT_BADOP]) begin
      bad_op_r <= 1'b0;
    end
  end

  // Register view selector
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      reg_sel_r <= 4'h0;
    end else if (wr_ok && (AVS_ADDRESS == ADDR_REGVW)) begin
      reg_sel_r <= AVS_WRITEDATA[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data captured in the waiting cycle, unmapped reads give zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rd_valid_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      rd_valid_r <= AVS_READ && !rd_valid_r;
      if (AVS_READ && !rd_valid_r) begin
        readdata_r <= 32'h0000_0000;
        unique case (AVS_ADDRESS)
          ADDR_INSTR:  readdata_r <= instr_r;
          ADDR_FLAGS:  readdata_r[7:0] <= flags_r;
          ADDR_STATUS: begin
            readdata_r[STAT_BUSY]               <= (state_r != ST_IDLE);
            readdata_r[STAT_BADOP]              <= bad_op_r;
            readdata_r[STAT_CNT_HI:STAT_CNT_LO] <= exec_cnt_r;
          end
          ADDR_REGVW:  readdata_r[11:0] <= {reg_sel_r, gpr_r[reg_sel_r]};
          ADDR_SP:     readdata_r[7:0] <= sp_r;
          default:     readdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// file: sim/bte_mem_model.sv
// Reference image of data memory, I/O space and working registers.
// Assumes the bench updates it beside every instruction it issues.
`timescale 1ns/100ps
module bte_mem_model;
  // Memory is not reset in the design, so only written bytes are compared
  logic [7:0] dmem [128];
  logic [7:0] io   [64];
  logic [7:0] gpr  [16] = '{default: 8'h00};
endmodule

// file: sim/bte_exec_checker.sv
// Concurrent checks on flag, pulse and issue behaviour of the executor.
// Assumes it is bound to bte_exec and sees only that module's ports.
`timescale 1ns/100ps
module bte_exec_checker import bte_pkg::*; (
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [7:0]  FLAG_REG,
  input wire logic        BREAK_PULSE,
  input wire logic        SLEEP_PULSE,
  input wire logic        WDOG_RESTART
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////
  // Issue word accepted in this cycle
  logic       iss;
  logic [5:0] opc;
  assign iss = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == ADDR_INSTR;
  assign opc = AVS_WRITEDATA[31:26];
  sequence s_iss(logic [5:0] c); iss && opc == c; endsequence
  sequence s_pulse(logic p); p ##1 !p; endsequence
  property p_ctl(logic [5:0] c, logic p); s_iss(c) |-> ##2 s_pulse(p); endproperty
  ////////////////////////////////////////////////////////////////////////////
  // Effect lands at the end of the execute cycle, seen two edges on
  AST_FLAG_SET: assert property (s_iss(OP_FLAG_SET) |-> ##2 FLAG_REG ==
    ($past(FLAG_REG, 2) | (8'h01 << $past(AVS_WRITEDATA[2:0], 2))))
    else $error("flag set op wrong flag byte");
  AST_FLAG_CLR: assert property (s_iss(OP_FLAG_CLR) |-> ##2 FLAG_REG ==
    ($past(FLAG_REG, 2) & ~(8'h01 << $past(AVS_WRITEDATA[2:0], 2))))
    else $error("flag clear op wrong flag byte");
  AST_CAP_ONLY_T: assert property (s_iss(OP_FLAG_CAP) |-> ##2
    (FLAG_REG & 8'hbf) == ($past(FLAG_REG, 2) & 8'hbf))
    else $error("bit capture touched another flag");
  AST_FLAGS_KEPT: assert property (iss && !(opc inside {OP_FLAG_SET, OP_FLAG_CLR,
    OP_FLAG_CAP}) |=> $stable(FLAG_REG) [*2])
    else $error("flags changed by a non-flag op");
  AST_BREAK: assert property (p_ctl(OP_BREAK, BREAK_PULSE))
    else $error("break pulse missing or long");
  AST_SLEEP: assert property (p_ctl(OP_SLEEP, SLEEP_PULSE))
    else $error("sleep pulse missing or long");
  AST_WDOG: assert property (p_ctl(OP_WDR, WDOG_RESTART))
    else $error("watchdog pulse missing or long");
  AST_NO_STRAY: assert property ($rose(BREAK_PULSE | SLEEP_PULSE | WDOG_RESTART)
    |-> $past(iss, 2))
    else $error("control pulse without an issued op");
endmodule
bind bte_exec bte_exec_checker u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLAG_REG(FLAG_REG), .BREAK_PULSE(BREAK_PULSE),
  .SLEEP_PULSE(SLEEP_PULSE), .WDOG_RESTART(WDOG_RESTART));

// file: sim/bte_exec_tb.sv
// Self-checking bench: issues words over Avalon-MM and reads results back.
// Assumes bte_exec, its checker bind and the reference image are compiled.
`timescale 1ns/100ps
module bte_exec_tb import bte_pkg::*; ;
  logic        SYS_CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic        BREAK_PULSE, SLEEP_PULSE, WDOG_RESTART;
  logic [4:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rq, seed;
  logic [7:0]  FLAG_REG, fl, a, sp;
  logic [2:0]  j;
  int          failures, check_count, cyc = 0;
  bte_op_t     po [8] = '{OP_ST_INC, OP_LD_DEC, OP_LD_INC, OP_ST_DEC, OP_LD, OP_ST,
                          OP_LD_INC, OP_LD_DEC};
  bte_op_t     co [5] = '{OP_BREAK, OP_SLEEP, OP_WDR, OP_IDLE, bte_op_t'(6'h3f)};
  bte_mem_model mdl ();
  bte_exec uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLAG_REG(FLAG_REG),
    .BREAK_PULSE(BREAK_PULSE), .SLEEP_PULSE(SLEEP_PULSE), .WDOG_RESTART(WDOG_RESTART));
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected execution length of each op
  function automatic logic [3:0] ncyc(bte_op_t o);
    return (o inside {OP_LD_INC, OP_LD_DEC, OP_ST_DEC, OP_PUSH, OP_POP}) ? 4'h2 : 4'h1;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(logic w, logic [4:0] ad, logic [31:0] d);
    @(posedge SYS_CLK);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
    rq = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rdc(string nm, logic [4:0] ad, logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    cmp(nm, e, rq);
  endtask
  // Issue, wait for idle, then check the recorded cycle count
  task automatic ex(bte_op_t o, logic [3:0] rd, logic [3:0] rr, logic [7:0] k, logic [2:0] bt);
    bus(1'b1, ADDR_INSTR, {o, 2'h0, rd, rr, k, 5'h00, bt});
    do bus(1'b0, ADDR_STATUS, 32'h0); while (rq[STAT_BUSY] !== 1'b0);
    cmp("cycles", {28'h0, ncyc(o)}, {28'h0, rq[STAT_CNT_HI:STAT_CNT_LO]});
  endtask
  task automatic rv(logic [3:0] i);
    bus(1'b1, ADDR_REGVW, {28'h0, i});
    rdc("regview", ADDR_REGVW, {20'h0, i, mdl.gpr[i]});
  endtask
  // Indirect access through X, modelling pointer and memory side effects
  task automatic ptr_op(bte_op_t o, logic [3:0] r);
    logic [15:0] p;
    p = {mdl.gpr[11], mdl.gpr[10]};
    if (o inside {OP_LD_DEC, OP_ST_DEC}) p = p - 16'h1;
    if (o inside {OP_ST, OP_ST_INC, OP_ST_DEC}) mdl.dmem[p[6:0]] = mdl.gpr[r];
    else mdl.gpr[r] = mdl.dmem[p[6:0]];
    if (o inside {OP_LD_INC, OP_ST_INC}) p = p + 16'h1;
    ex(o, r, r, 8'h00, 3'h0);
    {mdl.gpr[11], mdl.gpr[10]} = p;
    rv(r);
    rv(4'ha);
    rv(4'hb);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RESET = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_WRITEDATA = 32'h0;
    failures = 0;
    check_count = 0;
    seed = 32'h1930;
    sp = SP_RESET;
    repeat (6) @(posedge SYS_CLK);
    RESET <= 1'b0;
    // Reset values, unmapped hole, cleared register file
    rdc("flags", ADDR_FLAGS, FLAGS_RESET);
    rdc("sp", ADDR_SP, SP_RESET);
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("hole", 5'h14, 32'h0);
    for (int i = 0; i < 16; i++) rv(4'(i));
    // Every flag set and cleared over a random background
    fl = 8'(xs());
    bus(1'b1, ADDR_FLAGS, {24'h0, fl});
    for (int i = 0; i < 8; i++) begin
      fl[i] = 1'b1;
      ex(OP_FLAG_SET, 4'h0, 4'h0, 8'h00, 3'(i));
      rdc("flags", ADDR_FLAGS, fl);
      fl[i] = 1'b0;
      ex(OP_FLAG_CLR, 4'h0, 4'h0, 8'h00, 3'(i));
      rdc("flags", ADDR_FLAGS, fl);
    end
    // Immediate loads and a copy
    for (int i = 0; i < 10; i++) begin
      mdl.gpr[i] = 8'(xs());
      ex(OP_LDI, 4'(i), 4'h0, mdl.gpr[i], 3'h0);
      rv(4'(i));
    end
    ex(OP_COPY, 4'h3, 4'h5, 8'h00, 3'h0);
    mdl.gpr[3] = mdl.gpr[5];
    rv(4'h3);
    // Byte out, bit set, bit clear, byte back in
    a = 8'(xs()) & 8'h3f;
    j = 3'(xs());
    ex(OP_OUT, 4'h0, 4'h1, a, 3'h0);
    mdl.io[a[5:0]] = mdl.gpr[1];
    ex(OP_IO_SET, 4'h0, 4'h0, a, j);
    mdl.io[a[5:0]][j] = 1'b1;
    ex(OP_IO_CLR, 4'h0, 4'h0, a, j + 3'h1);
    mdl.io[a[5:0]][j + 3'h1] = 1'b0;
    ex(OP_IN, 4'h6, 4'h0, a, 3'h0);
    mdl.gpr[6] = mdl.io[a[5:0]];
    rv(4'h6);
    // Transfer flag round trips
    for (int i = 0; i < 4; i++) begin
      j = 3'(xs());
      ex(OP_FLAG_CAP, 4'h0, 4'h1, 8'h00, j);
      fl[FLG_TRANSFER] = mdl.gpr[1][j];
      rdc("flags", ADDR_FLAGS, fl);
      ex(OP_FLAG_RST, 4'h2, 4'h0, 8'h00, j + 3'h3);
      mdl.gpr[2][j + 3'h3] = fl[FLG_TRANSFER];
      rv(4'h2);
    end
    // Direct store then load at a random address
    a = 8'(xs()) & 8'h7f;
    ex(OP_STS, 4'h0, 4'h4, a, 3'h0);
    mdl.dmem[a[6:0]] = mdl.gpr[4];
    ex(OP_LDS, 4'h7, 4'h0, a, 3'h0);
    mdl.gpr[7] = mdl.dmem[a[6:0]];
    rv(4'h7);
    // X at 0x00ff so steps carry and borrow across the pair
    mdl.gpr[10] = 8'hff;
    mdl.gpr[11] = 8'h00;
    ex(OP_LDI, 4'ha, 4'h0, 8'hff, 3'h0);
    ex(OP_LDI, 4'hb, 4'h0, 8'h00, 3'h0);
    for (int i = 0; i < 8; i++) ptr_op(po[i], 4'(i));
    // Two pushes then two pops, last in first out
    for (int i = 0; i < 4; i++) begin
      if (i < 2) begin
        mdl.dmem[sp[6:0]] = mdl.gpr[i + 2];
        sp--;
        ex(OP_PUSH, 4'h0, 4'(i + 2), 8'h00, 3'h0);
      end else begin
        sp++;
        mdl.gpr[i + 2] = mdl.dmem[sp[6:0]];
        ex(OP_POP, 4'(i + 2), 4'h0, 8'h00, 3'h0);
        rv(4'(i + 2));
      end
      rdc("sp", ADDR_SP, sp);
    end
    // Control ops and an unknown code leave flags alone
    fl = 8'(xs());
    bus(1'b1, ADDR_FLAGS, {24'h0, fl});
    for (int i = 0; i < 5; i++) begin
      ex(co[i], 4'h0, 4'h0, 8'h00, 3'h0);
      rdc("flags", ADDR_FLAGS, fl);
    end
    rdc("status", ADDR_STATUS, 32'h102);
    bus(1'b1, ADDR_STATUS, 32'h2);
    rdc("status", ADDR_STATUS, 32'h100);
    test_done();
  end
endmodule
